//--- hw/seq_fault_pkg.sv
package seq_fault_pkg;
  // register addresses on the device's internal register port
  localparam logic [7:0] addr_power_on_status = 8'h1a;
  localparam logic [7:0] addr_power_off_status = 8'h1c;
  localparam logic [7:0] addr_sleep_exit_status = 8'h1e;
  localparam logic [7:0] addr_sleep_entry_status = 8'h20;
  // field layout
  localparam int num_channels = 6;
  localparam int pos_width = 4;
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [5:0] fault_reset = 6'h00;
  localparam logic [1:0] reserved_read = 2'h0;

  // one register access from the serial front end
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic hit;
  } reg_rsp_t;

  // per-channel recorded and expected positions for one sequence kind
  typedef struct packed {
    logic [num_channels*pos_width-1:0] recorded;
    logic [num_channels*pos_width-1:0] expected;
  } seq_positions_t;
endpackage : seq_fault_pkg

//--- hw/sequence_fault_status_bank.sv
`timescale 1ns/1ns
// How it works
// - power-on mismatch sets channel bit, bits 5:0
// - power-off mismatch sets channel bit
// - sleep-exit mismatch sets channel bit
// - sleep-entry mismatch sets channel bit
// - one bit per channel, channels one to six
// - set bits stay latched after condition clears
// - write one clears regardless of condition, but a same-cycle set wins
// - next matching sequence sets cleared bit again
// - reads one for fault, zero if disabled since last clear
// - activity rise is power-on, fall power-off
// - sleep rise is exit, fall is entry
module sequence_fault_status_bank (
  input wire logic ref_clk, // internal clock, 100 MHz
  input wire logic resetn, // synchronous reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire seq_fault_pkg::reg_req_t reg_req, // register access from serial port logic
  output seq_fault_pkg::reg_rsp_t reg_rsp, // registered read data and address hit
  input wire logic activity_control_input, // activity control pin, asynchronous
  input wire logic sleep_control_input, // sleep control pin, asynchronous
  input wire logic sequence_done, // pulse: sequence recording of the last edge complete
  input wire seq_fault_pkg::seq_positions_t power_on_positions, // record and expected, on
  input wire seq_fault_pkg::seq_positions_t power_off_positions, // record and expected, off
  input wire seq_fault_pkg::seq_positions_t sleep_exit_positions, // record and expected, exit
  input wire seq_fault_pkg::seq_positions_t sleep_entry_positions, // record and expected, entry
  input wire logic [5:0] power_on_fault_irq_enable, // per-channel enables
  input wire logic [5:0] power_off_fault_irq_enable, // per-channel enables
  input wire logic [5:0] sleep_exit_fault_irq_enable, // per-channel enables
  input wire logic [5:0] sleep_entry_fault_irq_enable, // per-channel enables
  output logic [5:0] power_on_fault_bit, // latched power-on faults
  output logic [5:0] power_off_fault_bit, // latched power-off faults
  output logic [5:0] sleep_exit_fault_bit, // latched sleep-exit faults
  output logic [5:0] sleep_entry_fault_bit // latched sleep-entry faults
);
  import seq_fault_pkg::*;

  typedef enum logic [2:0] {
    kind_none,
    kind_power_on,
    kind_power_off,
    kind_sleep_exit,
    kind_sleep_entry
  } seq_kind_t;

  // per-channel compare of recorded against expected position
  function automatic logic [5:0] mismatch(input seq_positions_t p);
    logic [5:0] m;
    m = fault_reset;
    for (int i = 0; i < num_channels; i++) begin
      m[i] = p.recorded[i*pos_width +: pos_width] != p.expected[i*pos_width +: pos_width];
    end
    return m;
  endfunction : mismatch

  // next value of one w1c register: set beats clear so a fault is never lost
  function automatic logic [5:0] w1c_next(input logic [5:0] cur, input logic [5:0] set,
                                          input logic wr, input logic [5:0] clr);
    logic [5:0] n;
    n = cur;
    if (wr) begin
      n = n & ~clr;
    end
    return n | set;
  endfunction : w1c_next

  // faults that land this cycle: the kind was pending and the channel is enabled
  function automatic logic [5:0] set_mask(input logic go, input logic [5:0] miss,
                                          input logic [5:0] en);
    logic [5:0] s;
    s = fault_reset;
    if (go) begin
      s = miss & en;
    end
    return s;
  endfunction : set_mask

  // register address compare, shared by the write strobes and the read select
  function automatic logic addr_match(input logic [7:0] a, input logic [7:0] target);
    logic m;
    m = a == target;
    return m;
  endfunction : addr_match

  // synchroniser and edge-detect stages of the two control pins
  logic act_meta_q;
  logic act_sync_q;
  logic act_prev_q;
  logic slp_meta_q;
  logic slp_sync_q;
  logic slp_prev_q;
  // pending sequence kind, held until its recording is reported final
  seq_kind_t kind_q;
  seq_kind_t kind_d;
  // latched status and its next value, one bit per channel
  logic [5:0] on_q;
  logic [5:0] off_q;
  logic [5:0] exs_q;
  logic [5:0] ens_q;
  logic [5:0] on_d;
  logic [5:0] off_d;
  logic [5:0] exs_d;
  logic [5:0] ens_d;
  // registered read answer
  logic [7:0] rdata_q;
  logic hit_q;

  // activity pin crosses into the clock domain through two flops before use;
  // the first flop may go metastable, so nothing else reads it
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      act_meta_q <= 1'b0;
      act_sync_q <= 1'b0;
    end else if (clk_en) begin
      act_meta_q <= activity_control_input;
      act_sync_q <= act_meta_q;
    end
  end

  // sleep pin takes the same two-flop path
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      slp_meta_q <= 1'b0;
      slp_sync_q <= 1'b0;
    end else if (clk_en) begin
      slp_meta_q <= sleep_control_input;
      slp_sync_q <= slp_meta_q;
    end
  end

  // last synchronised activity level, for the edge compare
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      act_prev_q <= 1'b0;
    end else if (clk_en) begin
      act_prev_q <= act_sync_q;
    end
  end

  // last synchronised sleep level, for the edge compare
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      slp_prev_q <= 1'b0;
    end else if (clk_en) begin
      slp_prev_q <= slp_sync_q;
    end
  end

  // edge classification; activity edges take priority over sleep edges
  wire act_rise = act_sync_q & ~act_prev_q;
  wire act_fall = ~act_sync_q & act_prev_q;
  wire slp_rise = slp_sync_q & ~slp_prev_q;
  wire slp_fall = ~slp_sync_q & slp_prev_q;

  // limitation: edges closer together than the recording time are not queued;
  // only the last one before done is judged
  // next pending kind; a new edge replaces an older one, done retires it
  always_comb begin
    kind_d = kind_q;
    if (act_rise) begin
      kind_d = kind_power_on;
    end else if (act_fall) begin
      kind_d = kind_power_off;
    end else if (slp_rise) begin
      kind_d = kind_sleep_exit;
    end else if (slp_fall) begin
      kind_d = kind_sleep_entry;
    end else if (sequence_done) begin
      kind_d = kind_none; // the evaluation is one-shot per sequence
    end
  end

  // the kind is remembered until the sequence completes, then compared once
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      kind_q <= kind_none;
    end else if (clk_en) begin
      kind_q <= kind_d;
    end
  end

  // which kind is waiting; at most one at a time
  wire pend_on = kind_q == kind_power_on;
  wire pend_off = kind_q == kind_power_off;
  wire pend_exs = kind_q == kind_sleep_exit;
  wire pend_ens = kind_q == kind_sleep_entry;

  // evaluation is one-shot, in the cycle the recording is reported final
  wire eval = sequence_done;
  wire eval_on = eval && pend_on;
  wire eval_off = eval && pend_off;
  wire eval_exs = eval && pend_exs;
  wire eval_ens = eval && pend_ens;

  // raw per-channel mismatches, before the enables
  wire [5:0] miss_on = mismatch(power_on_positions);
  wire [5:0] miss_off = mismatch(power_off_positions);
  wire [5:0] miss_exs = mismatch(sleep_exit_positions);
  wire [5:0] miss_ens = mismatch(sleep_entry_positions);

  // a disabled channel never sets, so it reads back zero unless it latched while enabled
  wire [5:0] set_on = set_mask(eval_on, miss_on, power_on_fault_irq_enable);
  wire [5:0] set_off = set_mask(eval_off, miss_off, power_off_fault_irq_enable);
  wire [5:0] set_exs = set_mask(eval_exs, miss_exs, sleep_exit_fault_irq_enable);
  wire [5:0] set_ens = set_mask(eval_ens, miss_ens, sleep_entry_fault_irq_enable);

  // host access strobes; the enable gates them like every other flop input,
  // so a frozen block neither clears nor answers, and the host must retry
  // an access that fell into a frozen cycle
  wire wr_go = clk_en && reg_req.wr_en;
  wire rd_go = clk_en && reg_req.rd_en;

  // address decode; reserved bits 7:6 of the write data are dropped
  wire wr_on = wr_go && addr_match(reg_req.addr, addr_power_on_status);
  wire wr_off = wr_go && addr_match(reg_req.addr, addr_power_off_status);
  wire wr_exs = wr_go && addr_match(reg_req.addr, addr_sleep_exit_status);
  wire wr_ens = wr_go && addr_match(reg_req.addr, addr_sleep_entry_status);
  wire [5:0] clr_bits = reg_req.wdata[num_channels-1:0];

  // per-register clear masks; zero bits clear nothing
  wire [5:0] clr_on = wr_on ? clr_bits : fault_reset;
  wire [5:0] clr_off = wr_off ? clr_bits : fault_reset;
  wire [5:0] clr_exs = wr_exs ? clr_bits : fault_reset;
  wire [5:0] clr_ens = wr_ens ? clr_bits : fault_reset;

  // next status: set beats clear so a fault found in the clear cycle is kept
  assign on_d = w1c_next(on_q, set_on, wr_on, clr_on);
  assign off_d = w1c_next(off_q, set_off, wr_off, clr_off);
  assign exs_d = w1c_next(exs_q, set_exs, wr_exs, clr_exs);
  assign ens_d = w1c_next(ens_q, set_ens, wr_ens, clr_ens);

  // power-on status; holds until a one is written
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      on_q <= fault_reset;
    end else if (clk_en) begin
      on_q <= on_d;
    end
  end

  // power-off status
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      off_q <= fault_reset;
    end else if (clk_en) begin
      off_q <= off_d;
    end
  end

  // sleep-exit status
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      exs_q <= fault_reset;
    end else if (clk_en) begin
      exs_q <= exs_d;
    end
  end

  // sleep-entry status
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ens_q <= fault_reset;
    end else if (clk_en) begin
      ens_q <= ens_d;
    end
  end

  // read select; unmapped addresses return zero with hit low
  wire hit_on = addr_match(reg_req.addr, addr_power_on_status);
  wire hit_off = addr_match(reg_req.addr, addr_power_off_status);
  wire hit_exs = addr_match(reg_req.addr, addr_sleep_exit_status);
  wire hit_ens = addr_match(reg_req.addr, addr_sleep_entry_status);
  wire [5:0] rd_on = hit_on ? on_q : fault_reset;
  wire [5:0] rd_off = hit_off ? off_q : fault_reset;
  wire [5:0] rd_exs = hit_exs ? exs_q : fault_reset;
  wire [5:0] rd_ens = hit_ens ? ens_q : fault_reset;
  wire [5:0] rd_bits = rd_on | rd_off | rd_exs | rd_ens;
  wire rd_hit = hit_on | hit_off | hit_exs | hit_ens;

  // read data only moves on a read, so it stands until the next one
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_q <= {reserved_read, fault_reset};
    end else if (rd_go) begin
      rdata_q <= {reserved_read, rd_bits};
    end
  end

  // address hit flag, updated together with the data
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hit_q <= 1'b0;
    end else if (rd_go) begin
      hit_q <= rd_hit;
    end
  end

  // outputs straight from the flops
  assign reg_rsp = {rdata_q, hit_q};
  assign power_on_fault_bit = on_q;
  assign power_off_fault_bit = off_q;
  assign sleep_exit_fault_bit = exs_q;
  assign sleep_entry_fault_bit = ens_q;
endmodule : sequence_fault_status_bank

//--- tb/seq_fault_assertions.sv
`timescale 1ns/1ns
module seq_fault_checker (
  input wire logic ref_clk, // clock
  input wire logic resetn, // sync reset, active low
  input wire logic clk_en, // run enable
  input wire seq_fault_pkg::reg_req_t reg_req, // register access
  input wire seq_fault_pkg::reg_rsp_t reg_rsp, // read answer
  input wire logic sequence_done, // sequence complete
  input wire logic [5:0] power_on_fault_irq_enable, // enables
  input wire logic [5:0] power_on_fault_bit, // status
  input wire logic [5:0] sleep_entry_fault_bit // status
);
  import seq_fault_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // a done in the same cycle may set a bit again, so clears are judged without it
  wire wr_on = clk_en && reg_req.wr_en && reg_req.addr == addr_power_on_status;
  wire rd_go = clk_en && reg_req.rd_en;
  AST_W1C: assert property (
    wr_on && !sequence_done |=> !(power_on_fault_bit & $past(reg_req.wdata[5:0])))
    else $error("status bit survived clear");
  AST_LATCH: assert property (!wr_on |=> !($past(power_on_fault_bit) & ~power_on_fault_bit))
    else $error("status bit fell without clear");
  AST_MASK: assert property (
    !(power_on_fault_bit & ~$past(power_on_fault_bit) & ~$past(power_on_fault_irq_enable)))
    else $error("disabled channel set");
  AST_DONE: assert property (
    sleep_entry_fault_bit & ~$past(sleep_entry_fault_bit) |-> $past(sequence_done))
    else $error("set without done");
  AST_READ: assert property (
    rd_go && reg_req.addr == addr_power_on_status
    |=> reg_rsp == {2'b00, $past(power_on_fault_bit), 1'b1}) else $error("bad read");
  AST_RSVD: assert property (reg_rsp.rdata[7:6] == 2'b00) else $error("reserved set");
  AST_UNMAP: assert property (rd_go && reg_req.addr[0] |=> reg_rsp == 9'h000)
    else $error("odd address answered");
  AST_HIT: assert property (rd_go && reg_req.addr == addr_sleep_entry_status |=> reg_rsp.hit)
    else $error("no hit");
  cover property (wr_on);
  cover property (sequence_done ##1 power_on_fault_bit != 6'h00);
  cover property (reg_rsp.hit);
endmodule : seq_fault_checker
bind sequence_fault_status_bank seq_fault_checker chk_u (.ref_clk(ref_clk), .resetn(resetn),
  .clk_en(clk_en), .reg_req(reg_req), .reg_rsp(reg_rsp), .sequence_done(sequence_done),
  .power_on_fault_irq_enable(power_on_fault_irq_enable),
  .power_on_fault_bit(power_on_fault_bit), .sleep_entry_fault_bit(sleep_entry_fault_bit));

//--- tb/host_model.sv
`timescale 1ns/1ns
module host_model (
  input wire logic ref_clk, // device clock
  output seq_fault_pkg::reg_req_t reg_req // access toward the bank
);
  import seq_fault_pkg::*;
  initial reg_req = '0;
  // one access per call, held a full cycle so the rising edge sees it settled
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_req = '{w, !w, a, d};
    @(negedge ref_clk);
    reg_req = '0;
  endtask : acc
endmodule : host_model

//--- tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import seq_fault_pkg::*;
  logic ref_clk = 0, resetn = 0, act = 0, slp = 0, done = 0, rd_d = 0;
  logic [5:0] en = '0, m, fo, ff, fx, fe;
  seq_positions_t pos = '0;
  reg_req_t req;
  reg_rsp_t rsp;
  logic [8:0] q[$];
  logic [7:0] adr [4] = '{addr_power_on_status, addr_sleep_exit_status,
    addr_sleep_entry_status, addr_power_off_status};
  integer seed = 32'h2550;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  host_model host_u (.ref_clk(ref_clk), .reg_req(req));
  sequence_fault_status_bank dut_u (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
    .reg_req(req), .reg_rsp(rsp), .activity_control_input(act), .sleep_control_input(slp),
    .sequence_done(done), .power_on_positions(pos), .power_off_positions(pos),
    .sleep_exit_positions(pos), .sleep_entry_positions(pos),
    .power_on_fault_irq_enable(en), .power_off_fault_irq_enable(en),
    .sleep_exit_fault_irq_enable(en), .sleep_entry_fault_irq_enable(en),
    .power_on_fault_bit(fo), .power_off_fault_bit(ff), .sleep_exit_fault_bit(fx),
    .sleep_entry_fault_bit(fe));
  task automatic chk(input logic [8:0] e, input logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    q.push_back(e);
    host_u.acc(1'b0, a, 8'h00);
  endtask : rd
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // read answers land one edge after the read; compare at the falling edge once settled
  always @(posedge ref_clk) rd_d <= req.rd_en;
  always @(negedge ref_clk) if (rd_d) chk(q.pop_front(), rsp);
  always @(posedge ref_clk) if (++cyc == 1000) begin
    n_fail++;
    end_of_test;
  end
  // each kind twice: the second pass sets bits again after they were cleared
  initial begin
    repeat (10) @(negedge ref_clk);
    resetn = 1;
    rd(8'h1b, 9'h000);
    for (int r = 0; r < 2; r++) for (int i = 0; i < 4; i++) begin
      m = 6'($random(seed));
      en = 6'($random(seed));
      for (int c = 0; c < 6; c++) pos.recorded[c*4+:4] = {3'b000, m[c]};
      act = (i < 3);
      slp = (i == 1);
      repeat (6) @(negedge ref_clk);
      done = 1;
      @(negedge ref_clk);
      done = 0;
      pos = '0;
      rd(adr[i], {2'b00, m & en, 1'b1});
      host_u.acc(1'b1, adr[i], 8'hc0);
      rd(adr[i], {2'b00, m & en, 1'b1});
      host_u.acc(1'b1, adr[i], 8'hff);
      rd(adr[i], 9'h001);
    end
    repeat (2) @(negedge ref_clk);
    end_of_test;
  end
endmodule : testbench
